//--- logic/sw_timer_pkg.sv
package sw_timer_pkg;

    // register map, byte offsets inside the configuration region
    localparam logic [11:0] MILLI_OFS     = 12'hC60;
    localparam logic [11:0] MICRO_OFS     = 12'hC62;
    localparam logic [11:0] CFG_OFS       = 12'hC64;

    // field layout and reset values
    localparam int          LATCH_W       = 10;
    localparam int          CFG_XTAL_BIT  = 0;
    localparam logic [15:0] MILLI_RST     = 16'h0000;
    localparam logic [15:0] MILLI_MAX     = 16'hFFFF;
    localparam logic [9:0]  LATCH_RST     = 10'h000;
    localparam logic [9:0]  MICRO_RST     = 10'h000;
    localparam logic [9:0]  MICRO_LAST    = 10'h3E7;
    localparam logic        CFG_RST       = 1'b0;

    // timing: clock period and the rates derived from it
    localparam longint unsigned CLK_PERIOD_NS = 64'd40;
    localparam longint unsigned CLK_HZ        = 64'd1000000000 / CLK_PERIOD_NS;
    localparam longint unsigned TICK_HZ       = 64'd1000000;
    localparam longint unsigned XTAL_NOM_KHZ  = 64'd33333;
    localparam longint unsigned XTAL_ALT_KHZ  = 64'd33000;

    // fractional divider: add STEP each cycle, tick when the sum reaches the clock rate, or its value scaled for the 33.000 MHz crystal
    localparam int          ACC_W         = 26;
    localparam logic [25:0] ACC_STEP      = 26'(TICK_HZ);
    localparam logic [25:0] ACC_LIM_NOM   = 26'(CLK_HZ);
    localparam logic [25:0] ACC_LIM_ALT   = 26'(CLK_HZ * XTAL_ALT_KHZ / XTAL_NOM_KHZ);
    localparam logic [25:0] ACC_RST       = 26'h0000000;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_UPPER = 2'b01
    } rd_state_type;

endpackage

//--- logic/us_tick_gen.sv
`timescale 1ns/1ps

module us_tick_gen
    import sw_timer_pkg::*;
(
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    // calibration
    input  wire logic i_crystal_select,
    // one-cycle 1 MHz enable
    output logic      o_tick
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] lim;
    logic             tick_d;

    // a slower crystal slows the processor clock, so fewer clocks make a microsecond
    assign lim = i_crystal_select ? ACC_LIM_ALT : ACC_LIM_NOM;
    assign sum = acc_q + ACC_STEP;

    always_comb begin
        acc_d  = sum;
        tick_d = 1'b0;
        if (sum >= lim) begin
            acc_d  = sum - lim;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_q  <= ACC_RST;
            o_tick <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            o_tick <= tick_d;
        end
    end

endmodule // us_tick_gen

//--- logic/software_ms_us_timer.sv
`timescale 1ns/1ps

// Behaviour
// - keep a 16-bit read-only millisecond count advancing 1000 times per second.
// - system reset forces the millisecond count to zero.
// - reading the millisecond count returns it, then clears it to zero, or to one if a microsecond wrap lands in the same cycle.
// - reading the microsecond latch leaves the millisecond count unchanged.
// - a millisecond read captures the live microsecond count into the latch.
// - microsecond counter ticks at 1 MHz, counts 0 to 999, then wraps.
// - every microsecond wrap adds one to the millisecond count.
// - a 32-bit millisecond read runs as two 16-bit reads, ms then latch.
// - combined result has milliseconds low and latched microseconds high.
// - decode milliseconds at C60h, latch at C62h, crystal config at C64h.
// - latch is 10 bits in 9..0, upper bits read zero, reset zero.
// - config bit 0 selects crystal, 0 for 33.333 MHz, 1 for 33.000 MHz.
// - crystal select steers only this timer's tick.
module software_ms_us_timer
    import sw_timer_pkg::*;
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    // register access
    input  wire logic [11:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic        i_wide,
    input  wire logic [15:0] i_wdata,
    // read answer
    output logic [31:0]      o_rdata,
    output logic             o_rvalid,
    output logic             o_busy
);

    rd_state_type        state_q;
    logic [9:0]          micro_q;
    logic [15:0]         milli_q;
    logic [LATCH_W-1:0]  latch_q;
    logic                crystal_select_q;
    logic                tick;
    logic                wrap;
    logic                rd_take;
    logic                wr_take;
    logic                rd_milli;
    logic                rd_split;
    logic [15:0]         rd_word;

    // a request arriving during the second half of a split read is dropped
    assign o_busy   = (state_q != ST_IDLE);
    assign rd_take  = i_rd && (state_q == ST_IDLE);
    assign wr_take  = i_wr && (state_q == ST_IDLE);
    assign rd_milli = rd_take && (i_addr == MILLI_OFS);
    assign rd_split = rd_milli && i_wide;

    // tick feeds nothing but this timer
    us_tick_gen u_tick (
        .i_mclk           (i_mclk),
        .i_nrst           (i_nrst),
        .i_crystal_select (crystal_select_q),
        .o_tick           (tick)
    );

    assign wrap = tick && (micro_q == MICRO_LAST);

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            micro_q <= MICRO_RST;
        end else if (wrap) begin
            micro_q <= MICRO_RST;
        end else if (tick) begin
            micro_q <= micro_q + 10'h001;
        end
    end

    // a wrap in the same cycle as a clearing read is kept: the count restarts at one
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            milli_q <= MILLI_RST;
        end else if (wrap && rd_milli) begin
            milli_q <= 16'h0001;
        end else if (wrap) begin
            milli_q <= milli_q + 16'h0001;
        end else if (rd_milli) begin
            milli_q <= MILLI_RST;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            latch_q <= LATCH_RST;
        end else if (rd_milli) begin
            latch_q <= micro_q;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            crystal_select_q <= CFG_RST;
        end else if (wr_take && (i_addr == CFG_OFS)) begin
            crystal_select_q <= i_wdata[CFG_XTAL_BIT];
        end
    end

    always_comb begin
        rd_word = 16'h0000;
        case (i_addr)
            MILLI_OFS: rd_word = milli_q;
            MICRO_OFS: rd_word = {6'h00, latch_q};
            CFG_OFS:   rd_word = {15'h0000, crystal_select_q};
            default:   rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:  state_q <= rd_split ? ST_UPPER : ST_IDLE;
                ST_UPPER: state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    // second half reads the latch after it has taken the new value
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata  <= 32'h00000000;
            o_rvalid <= 1'b0;
        end else if (state_q == ST_UPPER) begin
            o_rdata[31:16] <= {6'h00, latch_q};
            o_rvalid       <= 1'b1;
        end else if (rd_take) begin
            o_rdata  <= {16'h0000, rd_word};
            o_rvalid <= !rd_split;
        end else begin
            o_rvalid <= 1'b0;
        end
    end

    property p_micro_range;
        @(posedge i_mclk) disable iff (!i_nrst)
        micro_q <= MICRO_LAST;
    endproperty
    a_micro_range: assert property (p_micro_range) else $error("micro count past 999");

    property p_tick_gap;
        @(posedge i_mclk) disable iff (!i_nrst)
        tick |=> !tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");

    property p_wrap_inc;
        @(posedge i_mclk) disable iff (!i_nrst)
        (wrap && !rd_milli) |=> (milli_q == $past(milli_q) + 16'h0001);
    endproperty
    a_wrap_inc: assert property (p_wrap_inc) else $error("wrap did not add one");

    property p_milli_wrap;
        @(posedge i_mclk) disable iff (!i_nrst)
        (wrap && !rd_milli && milli_q == MILLI_MAX) |=> (milli_q == MILLI_RST);
    endproperty
    a_milli_wrap: assert property (p_milli_wrap) else $error("ms count did not wrap");

    property p_read_clear;
        @(posedge i_mclk) disable iff (!i_nrst)
        (rd_milli && !wrap) |=> (milli_q == MILLI_RST);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("ms read did not clear");

    property p_latch_cap;
        @(posedge i_mclk) disable iff (!i_nrst)
        rd_milli |=> (latch_q == $past(micro_q));
    endproperty
    a_latch_cap: assert property (p_latch_cap) else $error("latch missed micro count");

    property p_micro_read_keeps;
        @(posedge i_mclk) disable iff (!i_nrst)
        (rd_take && i_addr == MICRO_OFS && !wrap) |=> $stable(milli_q);
    endproperty
    a_micro_read_keeps: assert property (p_micro_read_keeps) else $error("latch read hit ms");

    property p_short_read;
        @(posedge i_mclk) disable iff (!i_nrst)
        (rd_milli && !i_wide) |=> (o_rvalid && o_rdata == {16'h0000, $past(milli_q)});
    endproperty
    a_short_read: assert property (p_short_read) else $error("16-bit ms read wrong");

    sequence s_split_start;
        rd_split;
    endsequence

    sequence s_split_done;
        ##1 (o_busy && !o_rvalid) ##1 (o_rvalid && !o_busy);
    endsequence

    property p_split_read;
        @(posedge i_mclk) disable iff (!i_nrst)
        s_split_start |-> s_split_done ##0
            (o_rdata == {6'h00, $past(micro_q, 2), $past(milli_q, 2)});
    endproperty
    a_split_read: assert property (p_split_read) else $error("32-bit ms read wrong");

    property p_cfg_write;
        @(posedge i_mclk) disable iff (!i_nrst)
        (wr_take && i_addr == CFG_OFS) |=> (crystal_select_q == $past(i_wdata[CFG_XTAL_BIT]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("crystal select not stored");

endmodule // software_ms_us_timer

//--- tb/software_ms_us_timer_tb.sv
`timescale 1ns/1ps

module software_ms_us_timer_tb;
    import sw_timer_pkg::*;

    logic        i_mclk      = 1'b0;
    logic        i_nrst      = 1'b0;
    logic [11:0] i_addr      = 12'h000;
    logic        i_rd        = 1'b0;
    logic        i_wr        = 1'b0;
    logic        i_wide      = 1'b0;
    logic [15:0] i_wdata     = 16'h0000;
    logic [31:0] o_rdata;
    logic        o_rvalid;
    logic        o_busy;
    int          fail_count  = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          take_cyc    = 0;
    int          last_cyc    = 0;
    int          sel         = 0;
    int          lat_q[$];
    logic [31:0] rd_val;
    logic [31:0] ms_val;

    software_ms_us_timer dut (
        .i_mclk   (i_mclk),
        .i_nrst   (i_nrst),
        .i_addr   (i_addr),
        .i_rd     (i_rd),
        .i_wr     (i_wr),
        .i_wide   (i_wide),
        .i_wdata  (i_wdata),
        .o_rdata  (o_rdata),
        .o_rvalid (o_rvalid),
        .o_busy   (o_busy)
    );

    always #20 i_mclk = ~i_mclk;

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
    end

    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%08h exp=%08h", $time, seen_v, exp_v);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // called at a falling edge; answers come at a fixed latency, so no wait loop is needed
    task automatic bus_read(input logic [11:0] a, input logic w, output logic [31:0] d);
        if (a == MILLI_OFS) begin
            take_cyc = cyc;
        end
        i_addr = a;
        i_wide = w;
        i_rd   = 1'b1;
        @(negedge i_mclk);
        i_rd   = 1'b0;
        i_wide = 1'b0;
        if (w && a == MILLI_OFS) begin
            chk({31'h0, o_busy}, 32'h1);
            chk({31'h0, o_rvalid}, 32'h0);
            @(negedge i_mclk);
        end
        chk({31'h0, o_rvalid}, 32'h1);
        d = o_rdata;
        // idle cycle so nothing lands in the busy window
        @(negedge i_mclk);
    endtask

    task automatic bus_write(input logic [11:0] a, input logic [15:0] d);
        i_addr  = a;
        i_wdata = d;
        i_wr    = 1'b1;
        @(negedge i_mclk);
        i_wr    = 1'b0;
    endtask

    // elapsed microseconds between two millisecond reads, from the clock count;
    // one count of slack covers tick phase, two with the fractional crystal step
    task automatic elapsed(input logic [31:0] ms, input logic [31:0] lat);
        int span;
        int tol;
        int got;
        int want;
        span = take_cyc - last_cyc;
        tol  = sel + 1;
        want = span / int'(CLK_HZ / TICK_HZ);
        if (sel == 1) begin
            want = span * int'(XTAL_NOM_KHZ) / (int'(CLK_HZ / TICK_HZ) * int'(XTAL_ALT_KHZ));
        end
        got = int'(ms) * 1000 + int'(lat) - lat_q[$];
        if (got >= want - tol && got <= want + tol) begin
            got = want;
        end
        chk(got, want);
        lat_q.push_back(int'(lat));
        last_cyc = take_cyc;
    endtask

    initial begin
        void'($urandom(32'hE27AFAF8));
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk);
        i_nrst = 1'b1;
        @(negedge i_mclk);
        bus_read(MICRO_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        bus_read(CFG_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        bus_read(12'hC66, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        // the millisecond count is read-only, a write must not land
        bus_write(MILLI_OFS, 16'hABCD);
        bus_read(MILLI_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        last_cyc = take_cyc;
        bus_read(MICRO_OFS, 1'b0, rd_val);
        chk({22'h0, rd_val[31:22]}, 32'h0);
        lat_q.push_back(int'(rd_val));
        for (int i = 0; i < 4; i++) begin
            sel = i % 2;
            bus_write(CFG_OFS, {15'($urandom), sel[0]});
            bus_read(CFG_OFS, 1'b0, rd_val);
            chk(rd_val, 32'(sel));
            repeat ($urandom_range(17000, 9000)) @(negedge i_mclk);
            // a latch read must neither clear nor move anything
            bus_read(MICRO_OFS, 1'b0, rd_val);
            chk(rd_val, 32'(lat_q[$]));
            bus_read(MILLI_OFS, 1'b1, rd_val);
            chk({26'h0, rd_val[31:26]}, 32'h0);
            elapsed({16'h0, rd_val[15:0]}, {16'h0, rd_val[31:16]});
            bus_read(MILLI_OFS, 1'b0, ms_val);
            chk({16'h0, ms_val[31:16]}, 32'h0);
            bus_read(MICRO_OFS, 1'b0, rd_val);
            elapsed(ms_val, rd_val);
        end
        // a read and a write landing in the busy half of a split read are both dropped
        i_addr = MILLI_OFS;
        i_wide = 1'b1;
        i_rd   = 1'b1;
        @(negedge i_mclk);
        i_addr  = CFG_OFS;
        i_wide  = 1'b0;
        i_wr    = 1'b1;
        i_wdata = 16'h0000;
        @(negedge i_mclk);
        i_rd = 1'b0;
        i_wr = 1'b0;
        chk({31'h0, o_rvalid}, 32'h1);
        @(negedge i_mclk);
        chk({31'h0, o_rvalid}, 32'h0);
        bus_read(CFG_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h1);
        // let more than a millisecond build up, then reset in mid-run
        repeat (25500) @(negedge i_mclk);
        i_nrst = 1'b0;
        repeat (3) @(negedge i_mclk);
        i_nrst = 1'b1;
        @(negedge i_mclk);
        bus_read(MICRO_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        bus_read(CFG_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        bus_read(MILLI_OFS, 1'b0, rd_val);
        chk(rd_val, 32'h0);
        results();
    end

endmodule // software_ms_us_timer_tb
